/* core/pcsp_cfg.svh */
`ifndef PCSP_CFG_SVH
`define PCSP_CFG_SVH

`define PCSP_PC_W        15
`define PCSP_PTR_W       16
`define PCSP_DADDR_W     13
`define PCSP_PWORD_W     14
`define PCSP_STACK_DEPTH 16
`define PCSP_DEPTH_W     5
`define PCSP_RESET_VEC   15'h0000
`define PCSP_INT_VEC     15'h0004
`define PCSP_PC_STEP     15'h0001
`define PCSP_LAST_PGM    15'h07FF
`define PCSP_PGM_SEL_BIT 15
`define PCSP_LIN_BASE    16'h2000
`define PCSP_LIN_LAST    16'h29AF
`define PCSP_GPR_SPAN    12'h050
`define PCSP_GPR_OFS     12'h020
`define PCSP_PTR_RST     16'h0000
`define PCSP_NUM_PTR     2

`endif

/* core/pcsp_pkg.sv */
`include "pcsp_cfg.svh"

package pcsp_pkg;
	// program-flow commands from the decoder
	typedef enum logic [2:0] {
		OP_NOP,
		OP_STEP,
		OP_JUMP,
		OP_CALL,
		OP_RET,
		OP_RETFIE,
		OP_INTR
	} pcsp_op_e;

	// indirect access fsm states
	typedef enum logic {
		IND_IDLE,
		IND_FETCH
	} pcsp_ind_e;

	typedef logic [`PCSP_PC_W-1:0]  pcsp_pc_t;
	typedef logic [`PCSP_PTR_W-1:0] pcsp_ptr_t;

	typedef struct packed {
		pcsp_op_e op;     // flow command
		pcsp_pc_t target; // jump or call target
	} pcsp_cmd_s;

	// core registers copied on interrupt entry
	typedef struct packed {
		logic [7:0] wreg;
		logic [4:0] status;
		logic [5:0] bank;
		logic [6:0] pclatch;
	} pcsp_ctx_s;

	typedef struct packed {
		logic       en;   // write strobe
		logic       sel;  // pointer 0 or 1
		logic       high; // high byte when set
		logic [7:0] data;
	} pcsp_ptrwr_s;

	typedef struct packed {
		logic       start; // access through data port
		logic       sel;
		logic       write;
		logic [7:0] wdata;
	} pcsp_indreq_s;

	typedef struct packed {
		logic                     re;
		logic                     we;
		logic [`PCSP_DADDR_W-1:0] addr;
		logic [7:0]               wdata;
	} pcsp_memreq_s;
endpackage : pcsp_pkg

/* core/pcsp_stack.sv */
`timescale 1ns/1ps
`include "pcsp_cfg.svh"

module pcsp_stack (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     clkEn,
	input  wire logic                     clear,
	input  wire logic                     push,
	input  wire logic                     pop,
	input  wire pcsp_pkg::pcsp_pc_t       pushData,
	output pcsp_pkg::pcsp_pc_t            topData,
	output logic                          overflow,
	output logic                          underflow,
	output logic [`PCSP_DEPTH_W-1:0]      depth
);
	import pcsp_pkg::*;

	pcsp_pc_t                 entry      [`PCSP_STACK_DEPTH]; // return addresses
	pcsp_pc_t                 next_entry [`PCSP_STACK_DEPTH];
	logic [`PCSP_DEPTH_W-1:0] next_depth;
	logic                     full;
	logic                     empty;

	assign full      = (depth == `PCSP_DEPTH_W'(`PCSP_STACK_DEPTH));
	assign empty     = (depth == '0);
	assign overflow  = push & full;
	assign underflow = pop & empty;
	// empty stack hands back the reset vector rather than stale data
	assign topData   = empty ? `PCSP_RESET_VEC : entry[4'(depth - 5'h01)];

	// occupancy count
	always_comb begin
		next_depth = depth;
		if (clear) begin
			next_depth = '0;
		end else if (push && !full) begin
			next_depth = depth + 5'h01;
		end else if (pop && !empty) begin
			next_depth = depth - 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			depth <= '0;
		end else if (clkEn) begin
			depth <= next_depth;
		end
	end

	// one storage word per level, a dedicated memory apart from data ram
	for (genvar i = 0; i < `PCSP_STACK_DEPTH; i++) begin : g_level
		always_comb begin
			next_entry[i] = entry[i];
			if (push && !full && !clear && depth == `PCSP_DEPTH_W'(i)) begin
				next_entry[i] = pushData;
			end
		end

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				entry[i] <= `PCSP_RESET_VEC;
			end else if (clkEn) begin
				entry[i] <= next_entry[i];
			end
		end
	end
endmodule : pcsp_stack

/* core/pcsp_top.sv */
`timescale 1ns/1ps
`include "pcsp_cfg.svh"

module pcsp_top (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  clkEn,
	input  wire pcsp_pkg::pcsp_cmd_s   cmd,
	input  wire pcsp_pkg::pcsp_ctx_s   ctxIn,
	input  wire pcsp_pkg::pcsp_ptrwr_s ptrWr,
	input  wire pcsp_pkg::pcsp_indreq_s indReq,
	input  wire logic [`PCSP_PWORD_W-1:0] pgmData,
	input  wire logic                  stackRstEn,
	input  wire logic                  clrOverflow,
	input  wire logic                  clrUnderflow,
	output pcsp_pkg::pcsp_pc_t         pc,
	output logic                       pcBeyondLast,
	output pcsp_pkg::pcsp_ptr_t        ptr0,
	output pcsp_pkg::pcsp_ptr_t        ptr1,
	output pcsp_pkg::pcsp_ctx_s        shadowCtx,
	output logic                       ctxRestore,
	output pcsp_pkg::pcsp_memreq_s     memReq,
	output logic                       pgmRe,
	output pcsp_pkg::pcsp_pc_t         pgmAddr,
	output logic [7:0]                 indRdData,
	output logic                       indBusy,
	output logic                       stack_overflow_flag,
	output logic                       stack_underflow_flag,
	output logic                       swResetReq,
	output logic [`PCSP_DEPTH_W-1:0]   stackDepth
);
	import pcsp_pkg::*;

	// flow control and stack hookup
	pcsp_pc_t  next_pc;
	logic      next_pcBeyondLast;
	logic      push;
	logic      pop;
	pcsp_pc_t  pushData;
	pcsp_pc_t  topData;
	logic      ovfEvt;
	logic      unfEvt;
	pcsp_op_e  effOp;            // command after stall gating

	// status flags and self reset
	logic      next_ovfFlag;
	logic      next_unfFlag;
	logic      next_swResetReq;

	// shadow context
	pcsp_ctx_s next_shadowCtx;
	pcsp_ptr_t shadowPtr      [`PCSP_NUM_PTR];
	pcsp_ptr_t next_shadowPtr [`PCSP_NUM_PTR];
	logic      next_ctxRestore;
	logic      save;
	logic      restore;

	// indirect pointers and access
	pcsp_ptr_t    ptr      [`PCSP_NUM_PTR];
	pcsp_ptr_t    next_ptr [`PCSP_NUM_PTR];
	pcsp_ind_e    indState;
	pcsp_ind_e    next_indState;
	pcsp_memreq_s next_memReq;
	logic         next_pgmRe;
	pcsp_pc_t     next_pgmAddr;
	logic [7:0]   next_indRdData;
	pcsp_ptr_t    selPtr;
	logic [11:0]  linOfs;         // offset into linear window
	logic [11:0]  linBank;
	logic [11:0]  linIdx;
	logic [`PCSP_DADDR_W-1:0] mappedAddr;

	assign ptr0    = ptr[0];
	assign ptr1    = ptr[1];
	// the decoder holds its next command while the program word is fetched
	assign indBusy = (indState == IND_FETCH);
	assign effOp   = indBusy ? OP_NOP : cmd.op;

	pcsp_stack u_stack (
		.clk       (clk),
		.rst_n     (rst_n),
		.clkEn     (clkEn),
		.clear     (swResetReq),
		.push      (push),
		.pop       (pop),
		.pushData  (pushData),
		.topData   (topData),
		.overflow  (ovfEvt),
		.underflow (unfEvt),
		.depth     (stackDepth)
	);

	// program counter next value
	always_comb begin
		next_pc  = pc;
		push     = 1'b0;
		pop      = 1'b0;
		pushData = pc + `PCSP_PC_STEP;
		save     = 1'b0;
		restore  = 1'b0;
		if (swResetReq) begin
			next_pc = `PCSP_RESET_VEC;
		end else begin
			unique case (effOp)
				OP_NOP: begin
					next_pc = pc;
				end
				OP_STEP: begin
					next_pc = pc + `PCSP_PC_STEP;
				end
				OP_JUMP: begin
					next_pc = cmd.target;
				end
				OP_CALL: begin
					push    = 1'b1;
					next_pc = cmd.target;
				end
				OP_RET: begin
					pop     = 1'b1;
					next_pc = topData;
				end
				OP_RETFIE: begin
					pop     = 1'b1;
					restore = 1'b1;
					next_pc = topData;
				end
				OP_INTR: begin
					// the interrupted instruction has not run, so it is the return point
					push     = 1'b1;
					pushData = pc;
					save     = 1'b1;
					next_pc  = `PCSP_INT_VEC;
				end
			endcase
		end
		// fetch beyond implemented memory is flagged, not wrapped
		next_pcBeyondLast = (next_pc > `PCSP_LAST_PGM);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pc           <= `PCSP_RESET_VEC;
			pcBeyondLast <= 1'b0;
		end else if (clkEn) begin
			pc           <= next_pc;
			pcBeyondLast <= next_pcBeyondLast;
		end
	end

	// sticky stack flags and error reset; a set beats a same-cycle clear
	always_comb begin
		next_ovfFlag    = ovfEvt | (stack_overflow_flag & ~clrOverflow);
		next_unfFlag    = unfEvt | (stack_underflow_flag & ~clrUnderflow);
		next_swResetReq = stackRstEn & (ovfEvt | unfEvt) & ~swResetReq;
	end

	// flags survive the self reset so software can see its cause
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stack_overflow_flag  <= 1'b0;
			stack_underflow_flag <= 1'b0;
			swResetReq           <= 1'b0;
		end else if (clkEn) begin
			stack_overflow_flag  <= next_ovfFlag;
			stack_underflow_flag <= next_unfFlag;
			swResetReq           <= next_swResetReq;
		end
	end

	// shadow copy of core registers
	always_comb begin
		next_shadowCtx  = shadowCtx;
		next_ctxRestore = restore & ~swResetReq;
		if (save) begin
			next_shadowCtx = ctxIn;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shadowCtx  <= '0;
			ctxRestore <= 1'b0;
		end else if (clkEn) begin
			shadowCtx  <= next_shadowCtx;
			ctxRestore <= next_ctxRestore;
		end
	end

	// one pointer and its shadow per channel
	for (genvar i = 0; i < `PCSP_NUM_PTR; i++) begin : g_ptr
		always_comb begin
			next_ptr[i]       = ptr[i];
			next_shadowPtr[i] = shadowPtr[i];
			if (save) begin
				next_shadowPtr[i] = ptr[i];
			end
			if (swResetReq) begin
				next_ptr[i] = `PCSP_PTR_RST;
			end else if (restore) begin
				next_ptr[i] = shadowPtr[i];
			end else if (ptrWr.en && ptrWr.sel == 1'(i)) begin
				if (ptrWr.high) begin
					next_ptr[i] = {ptrWr.data, ptr[i][7:0]};
				end else begin
					next_ptr[i] = {ptr[i][15:8], ptrWr.data};
				end
			end
		end

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				ptr[i]       <= `PCSP_PTR_RST;
				shadowPtr[i] <= `PCSP_PTR_RST;
			end else if (clkEn) begin
				ptr[i]       <= next_ptr[i];
				shadowPtr[i] <= next_shadowPtr[i];
			end
		end
	end

	// pointer to data address: linear window folds onto the gpr of banks 0 to 30
	always_comb begin
		selPtr     = ptr[indReq.sel];
		linOfs     = 12'(selPtr - `PCSP_LIN_BASE);
		linBank    = linOfs / `PCSP_GPR_SPAN;
		linIdx     = (linOfs % `PCSP_GPR_SPAN) + `PCSP_GPR_OFS;
		mappedAddr = selPtr[`PCSP_DADDR_W-1:0];
		if (selPtr >= `PCSP_LIN_BASE && selPtr <= `PCSP_LIN_LAST) begin
			mappedAddr = {linBank[5:0], linIdx[6:0]};
		end
	end

	// indirect data port sequencing
	always_comb begin
		next_indState  = indState;
		next_memReq    = '0;
		next_pgmRe     = 1'b0;
		next_pgmAddr   = pgmAddr;
		next_indRdData = indRdData;
		if (swResetReq) begin
			next_indState = IND_IDLE;
		end else begin
			unique case (indState)
				IND_IDLE: begin
					if (indReq.start && selPtr[`PCSP_PGM_SEL_BIT]) begin
						// program target: writes are dropped, reads stall a cycle
						if (!indReq.write) begin
							next_pgmRe    = 1'b1;
							next_pgmAddr  = selPtr[`PCSP_PC_W-1:0];
							next_indState = IND_FETCH;
						end
					end else if (indReq.start) begin
						next_memReq.re    = ~indReq.write;
						next_memReq.we    = indReq.write;
						next_memReq.addr  = mappedAddr;
						next_memReq.wdata = indReq.wdata;
					end
				end
				IND_FETCH: begin
					next_indRdData = pgmData[7:0];
					next_indState  = IND_IDLE;
				end
			endcase
		end
	end

	// program memory is modelled as answering within the fetch cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			indState  <= IND_IDLE;
			memReq    <= '0;
			pgmRe     <= 1'b0;
			pgmAddr   <= `PCSP_RESET_VEC;
			indRdData <= 8'h00;
		end else if (clkEn) begin
			indState  <= next_indState;
			memReq    <= next_memReq;
			pgmRe     <= next_pgmRe;
			pgmAddr   <= next_pgmAddr;
			indRdData <= next_indRdData;
		end
	end
endmodule : pcsp_top

/* dv/pcsp_chk.sv */
`timescale 1ns/1ps
`include "pcsp_cfg.svh"

module pcsp_chk (
	input wire logic                     clk,
	input wire logic                     rst_n,
	input wire logic                     clkEn,
	input wire logic                     stackRstEn,
	input wire pcsp_pkg::pcsp_cmd_s      cmd,
	input wire pcsp_pkg::pcsp_indreq_s   indReq,
	input wire pcsp_pkg::pcsp_pc_t       pc,
	input wire pcsp_pkg::pcsp_ptr_t      ptr0,
	input wire pcsp_pkg::pcsp_ptr_t      ptr1,
	input wire logic                     pgmRe,
	input wire pcsp_pkg::pcsp_pc_t       pgmAddr,
	input wire logic                     indBusy,
	input wire pcsp_pkg::pcsp_memreq_s   memReq,
	input wire logic                     stack_overflow_flag,
	input wire logic                     stack_underflow_flag,
	input wire logic                     swResetReq,
	input wire logic [`PCSP_DEPTH_W-1:0] stackDepth
);
	import pcsp_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic      go;     // command really taken this edge
	logic      isPop;  // return of either kind
	pcsp_ptr_t sp;     // pointer named by the request
	assign go = clkEn && !indBusy && !swResetReq;
	assign isPop = cmd.op == OP_RET || cmd.op == OP_RETFIE;
	assign sp = indReq.sel ? ptr1 : ptr0;

	// the sum is cut to fifteen bits so a step from 7FFFh wraps to zero
	step_pc_a: assert property (go && cmd.op == OP_STEP |=> pc == 15'($past(pc) + 1))
		else $error("pc did not advance by one");
	call_push_a: assert property (go && cmd.op == OP_CALL && stackDepth < 16
		|=> pc == $past(cmd.target) && stackDepth == $past(stackDepth) + 1)
		else $error("call did not push and jump");
	intr_vec_a: assert property (go && cmd.op == OP_INTR |=> pc == `PCSP_INT_VEC)
		else $error("interrupt did not reach vector");
	reset_pc_a: assert property (disable iff (1'b0) !rst_n && clkEn
		|=> pc == `PCSP_RESET_VEC && stackDepth == 0)
		else $error("reset did not clear pc");
	ovf_flag_a: assert property (go && stackDepth == 16 && cmd.op inside {OP_CALL, OP_INTR}
		|=> stack_overflow_flag && stackDepth == 16)
		else $error("overflow not flagged");
	unf_flag_a: assert property (go && stackDepth == 0 && isPop
		|=> stack_underflow_flag && pc == 0)
		else $error("underflow not flagged");
	err_reset_a: assert property (go && stackRstEn && stackDepth == 0 && isPop
		|=> ##[0:1] swResetReq ##1 (pc == 0 && stackDepth == 0))
		else $error("stack error did not reset");
	pgm_fetch_a: assert property (go && indReq.start && !indReq.write && sp[15]
		|=> pgmRe && indBusy && pgmAddr == $past(sp[14:0]) ##1 !indBusy && !pgmRe)
		else $error("program fetch timing wrong");
	pgm_wr_a: assert property (go && indReq.start && indReq.write && sp[15]
		|=> !memReq.we && !memReq.re && !pgmRe)
		else $error("program write not dropped");
	depth_cap_a: assert property (stackDepth <= 16)
		else $error("stack depth above sixteen");

	cover property (go && cmd.op == OP_INTR);
	cover property (swResetReq);
	cover property (indBusy);
endmodule : pcsp_chk

bind pcsp_top pcsp_chk pcsp_chk_inst (.*);

/* dv/pcsp_pgm_model.sv */
`timescale 1ns/1ps
`include "pcsp_cfg.svh"

module pcsp_pgm_model (
	input wire logic                pgmRe,
	input wire pcsp_pkg::pcsp_pc_t  pgmAddr,
	output logic [`PCSP_PWORD_W-1:0] pgmData
);
	import pcsp_pkg::*;
	logic [`PCSP_PWORD_W-1:0] word; // stored word, address folded in
	assign word = {pgmAddr[5:0], pgmAddr[7:0] ^ 8'h5A};
	// outside a read the word is inverted so stale data cannot pass
	assign pgmData = pgmRe ? word : ~word;
endmodule : pcsp_pgm_model

/* dv/tb_program_counter_stack_pointers.sv */
`timescale 1ns/1ps
`include "pcsp_cfg.svh"

module tb_program_counter_stack_pointers;
	import pcsp_pkg::*;
	logic clk = 0, rst_n = 0, clkEn = 1, stackRstEn = 0;
	logic clrOverflow = 0, clrUnderflow = 0, ctxRestore, pgmRe, indBusy, pcBeyondLast;
	logic stack_overflow_flag, stack_underflow_flag, swResetReq;
	logic [1:0]   seenBusy;    // pgmRe and indBusy as they stood after the taking edge
	pcsp_cmd_s    cmd = '0;    // flow command to the block
	pcsp_ctx_s    ctxIn = '0, shadowCtx;
	pcsp_ptrwr_s  ptrWr = '0;
	pcsp_indreq_s indReq = '0;
	pcsp_memreq_s memReq, seenReq; // seenReq: one-cycle request caught while it stands
	pcsp_pc_t     pc, pgmAddr;
	pcsp_ptr_t    ptr0, ptr1;
	logic [`PCSP_PWORD_W-1:0] pgmData;
	logic [7:0]   indRdData;
	logic [`PCSP_DEPTH_W-1:0] stackDepth;
	int error_cnt = 0, compares = 0;

	pcsp_top pcsp_top_inst (.*);
	pcsp_pgm_model pcsp_pgm_model_inst (.pgmRe(pgmRe), .pgmAddr(pgmAddr), .pgmData(pgmData));

	always #10 clk = ~clk;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	// one command for one cycle, then an idle edge so that back-to-back calls
	// never reassign cmd in one time step; standing outputs are settled on return
	task issue(input pcsp_op_e op, input pcsp_pc_t tgt);
		cmd = '{op, tgt};
		@(negedge clk);
		cmd = '{OP_NOP, 15'h0000};
		@(negedge clk);
	endtask : issue

	task wrPtr(input logic sel, input pcsp_ptr_t v);
		ptrWr = '{1'b1, sel, 1'b1, v[15:8]};
		@(negedge clk);
		ptrWr = '{1'b1, sel, 1'b0, v[7:0]};
		@(negedge clk);
		ptrWr = '0;
		@(negedge clk);
	endtask : wrPtr

	// one access; the one-cycle answers are caught in the cycle they stand,
	// and the idle edge after it lets a program fetch finish
	task ind(input logic sel, input logic wr, input logic [7:0] d);
		indReq = '{1'b1, sel, wr, d};
		@(negedge clk);
		indReq = '0;
		seenReq = memReq;
		seenBusy = {pgmRe, indBusy};
		@(negedge clk);
	endtask : ind

	// flags need a clear pulse and one more edge
	task clrFlags;
		{clrOverflow, clrUnderflow} = 2'h3;
		@(negedge clk);
		{clrOverflow, clrUnderflow} = 2'h0;
		@(negedge clk);
		chk({stack_overflow_flag, stack_underflow_flag}, 0);
	endtask : clrFlags

	task t_flow;
		chk(pc, 0);
		chk(stackDepth, 0);
		issue(OP_JUMP, `PCSP_LAST_PGM);
		issue(OP_NOP, 0);
		chk(pcBeyondLast, 0);
		issue(OP_STEP, 0);
		issue(OP_NOP, 0);
		chk(pcBeyondLast, 1);
		issue(OP_CALL, 15'h0123);
		chk(pc, 32'h123);
		issue(OP_RET, 0);
		chk(pc, 32'h801);
		issue(OP_JUMP, 15'h7FFF);
		issue(OP_STEP, 0);
		chk(pc, 0);
	endtask : t_flow

	// fill all sixteen levels, overflow, drain, underflow
	task t_stack;
		issue(OP_JUMP, 15'h0040);
		for (int i = 0; i < 16; i++) issue(OP_CALL, 15'h0100 + i[14:0]);
		chk(stackDepth, 16);
		issue(OP_CALL, 15'h0555);
		chk(stack_overflow_flag, 1);
		chk(stackDepth, 16);
		for (int i = 15; i > 0; i--) begin
			issue(OP_RET, 0);
			chk(pc, 32'h100 + i);
		end
		issue(OP_RET, 0);
		chk(pc, 32'h41);
		issue(OP_RET, 0);
		chk(stack_underflow_flag, 1);
		chk(pc, 0);
		clrFlags();
	endtask : t_stack

	task t_errRst;
		stackRstEn = 1;
		wrPtr(0, 16'h1234);
		issue(OP_JUMP, 15'h0033);
		// pop from empty by hand: the reset pulse stands only one cycle
		cmd = '{OP_RET, 15'h0000};
		@(negedge clk);
		cmd = '{OP_NOP, 15'h0000};
		chk(swResetReq, 1);
		@(negedge clk);
		chk(swResetReq, 0);
		chk(pc, 0);
		chk(ptr0, 0);
		stackRstEn = 0;
		clrFlags();
	endtask : t_errRst

	task t_intr;
		wrPtr(0, 16'h2055);
		wrPtr(1, 16'h8010);
		issue(OP_JUMP, 15'h0200);
		ctxIn = 26'h2ABCDEF;
		issue(OP_INTR, 0);
		chk(pc, 4);
		chk(shadowCtx, 26'h2ABCDEF);
		ctxIn = '0;
		wrPtr(0, 16'h0123);
		// return by hand: the restore strobe stands only one cycle
		cmd = '{OP_RETFIE, 15'h0000};
		@(negedge clk);
		cmd = '{OP_NOP, 15'h0000};
		chk(ctxRestore, 1);
		@(negedge clk);
		chk(ctxRestore, 0);
		chk(pc, 32'h200);
		chk(ptr0, 32'h2055);
		chk(ptr1, 32'h8010);
	endtask : t_intr

	task t_ind;
		ind(1, 0, 0);
		chk(seenBusy, 3);
		chk(pgmAddr, 32'h10);
		chk(indBusy, 0);
		chk(indRdData, 32'h4A);
		ind(1, 1, 8'hA5);
		chk({seenReq.we, seenReq.re, seenBusy[1]}, 0);
		ind(0, 0, 0);
		chk(seenReq.re, 1);
		chk(seenReq.addr, 32'h0A5);
		wrPtr(0, 16'h29AF);
		ind(0, 0, 0);
		chk(seenReq.addr, 32'hF6F);
		wrPtr(0, 16'h0123);
		ind(0, 1, 8'h3C);
		chk({seenReq.we, seenReq.addr, seenReq.wdata}, {1'b1, 13'h0123, 8'h3C});
	endtask : t_ind

	// enable low freezes a waiting step; a mid-run reset clears live state
	task t_hold;
		clkEn = 0;
		cmd = '{OP_STEP, 15'h0000};
		repeat (3) @(negedge clk);
		chk(pc, 32'h200);
		clkEn = 1;
		@(negedge clk);
		cmd = '{OP_NOP, 15'h0000};
		chk(pc, 32'h201);
		rst_n = 0;
		@(negedge clk);
		rst_n = 1;
		chk(pc, 0);
		chk(ptr0, 0);
		chk(stackDepth, 0);
	endtask : t_hold

	task summarize;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	// hang guard
	initial begin
		#1000000;
		error_cnt++;
		summarize();
	end

	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1;
		t_flow();
		t_stack();
		t_errRst();
		t_intr();
		t_ind();
		t_hold();
		summarize();
	end
endmodule : tb_program_counter_stack_pointers
